// ### pkg/asb_defines.vh
// Register map, field positions and sizing constants of the sample buffer.
`ifndef ASB_DEFINES_VH
`define ASB_DEFINES_VH

// ====================================================================
// Register addresses (write address; reads add the read flag)
`define ASB_ADDR_THRESH     7'h32
`define ASB_ADDR_MODE       7'h33
`define ASB_ADDR_LEVEL      7'h34
`define ASB_ADDR_STAT2      7'h35
`define ASB_ADDR_CLEAR      7'h36
`define ASB_ADDR_BUFRD      7'h7F
`define ASB_RD_FLAG_BIT     7

// ====================================================================
// Field positions and reset values
`define ASB_ACTIVE_BIT      7
`define ASB_RES_BIT         6
`define ASB_MODE_HI_BIT     1
`define ASB_MODE_LO_BIT     0
`define ASB_TRIG_BIT        7
`define ASB_THRESH_MSB      6
`define ASB_THRESH_RST      7'h00
`define ASB_MODE_RST        8'h00
`define ASB_MODE_CTRL_MASK  8'hC3

// ====================================================================
// Buffer modes
`define ASB_BM_FIFO         2'h0
`define ASB_BM_STREAM       2'h1
`define ASB_BM_TRIG         2'h2
`define ASB_BM_LIFO         2'h3

// ====================================================================
// Capacities, bytes per sample set and widths
`define ASB_CAP_HI          7'h29
`define ASB_CAP_LO          7'h54
`define ASB_BYTES_HI        3'h6
`define ASB_BYTES_LO        3'h3
`define ASB_DEPTH           84
`define ASB_AXIS_W          12
`define ASB_STAGE_DEPTH     8
`define ASB_STAGE_AW        3
`define ASB_SYNC_RST        3'h4

`endif

// ### rtl/asb_fifo.v
// Small staging FIFO with valid/ready on both sides and a flush input.
`timescale 1ns/10ps
module asb_fifo #(
    parameter WIDTH = 36,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_n,
    input  wire             flush,
    // Filling side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Draining side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      fill;

    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;

    assign in_ready  = (fill != DEPTH[AW:0]);
    assign out_valid = (fill != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];

    // Pointers wrap explicitly so that a depth that is not a power of two works.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            fill   <= {(AW+1){1'b0}};
        end else if (flush) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            fill   <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push & ~pop) begin
                fill <= fill + 1'b1;
            end else if (pop & ~push) begin
                fill <= fill - 1'b1;
            end
        end
    end

    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule

// ### rtl/asb_buffer_ctrl.v
// Three-axis sample buffer with SPI register access and four buffer modes.
//
// Functional notes
// RL1 - Threshold raises watermark in non-trigger modes.
// RL2 - Capacity 41 sets high, 84 sets low.
// RL3 - Trigger mode: threshold sets pre-trigger samples kept.
// RL4 - Control bit 7 activates sample collection.
// RL5 - Control bit 6 selects 12-bit or 8-bit.
// RL6 - Bits 1:0 select buffer mode.
// RL7 - FIFO mode stops when full.
// RL8 - Stream mode drops oldest when full.
// RL9 - Trigger: keep pre-samples, then fill until full.
// RL10 - Newest-first mode drops oldest, reads newest first.
// RL11 - Fill level counts bytes, six or three.
// RL12 - Fill level zero only when empty.
// RL13 - Clear write empties buffer and status; a same-cycle trigger still sets the trigger flag.
// RL14 - Set-wise auto-increment reads block storing.
// RL15 - Output data is two's complement.
// RL16 - Status bit 7 shows trigger seen.
// RL17 - Reads use write address with bit 7.
// RL18 - One sample per output data period.
`timescale 1ns/10ps
`include "asb_defines.vh"
module asb_buffer_ctrl #(
    parameter DEPTH = `ASB_DEPTH,
    parameter AXW   = `ASB_AXIS_W
) (
    // Clock and reset
    input  wire           clk,
    input  wire           rst_n,
    // SPI pins
    input  wire           spi_sclk,
    input  wire           spi_cs_n,
    input  wire           spi_mosi,
    output wire           spi_miso,
    output wire           spi_miso_oe,
    // Sample stream from the sensor core, one set per output data period
    input  wire           sample_valid,
    output wire           sample_ready,
    input  wire [AXW-1:0] sample_x,
    input  wire [AXW-1:0] sample_y,
    input  wire [AXW-1:0] sample_z,
    // Trigger event from the sensor core
    input  wire           trigger_event,
    // Status
    output wire           watermark
);

    localparam SW = 3 * AXW;
    localparam [7:0] MODE_RST = `ASB_MODE_RST;
    localparam [2:0] SYNC_RST = `ASB_SYNC_RST;

    // ================================================================
    // Pin synchronisers
    wire [2:0] pin_raw = {spi_cs_n, spi_sclk, spi_mosi};
    reg  [2:0] sync1;
    reg  [2:0] sync2;
    reg  [2:0] sync3;
    reg  [2:0] pin_filt;
    reg  [2:0] pin_prev;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            // A change counts only once the last two stages agree.
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1[gi]    <= SYNC_RST[gi];
                    sync2[gi]    <= SYNC_RST[gi];
                    sync3[gi]    <= SYNC_RST[gi];
                    pin_filt[gi] <= SYNC_RST[gi];
                    pin_prev[gi] <= SYNC_RST[gi];
                end else begin
                    sync1[gi]    <= pin_raw[gi];
                    sync2[gi]    <= sync1[gi];
                    sync3[gi]    <= sync2[gi];
                    if (sync2[gi] == sync3[gi]) begin
                        pin_filt[gi] <= sync3[gi];
                    end
                    pin_prev[gi] <= pin_filt[gi];
                end
            end
        end
    endgenerate

    wire cs_act    = ~pin_filt[2];
    wire sclk_rise = pin_filt[1] & ~pin_prev[1];
    wire sclk_fall = ~pin_filt[1] & pin_prev[1];
    wire mosi_bit  = pin_filt[0];

    // ================================================================
    // Configuration registers
    reg  [6:0] sample_threshold;
    reg        buffer_active;
    reg        sample_resolution_sel;
    reg        buffer_mode_hi;
    reg        buffer_mode_lo;
    reg        trigger_seen_flag;

    wire [1:0] mode = {buffer_mode_hi, buffer_mode_lo};
    wire       newest_first_mode = (mode == `ASB_BM_LIFO);

    // ================================================================
    // SPI slave state
    reg  [2:0] bit_cnt;
    reg  [7:0] rx_sh;
    reg        first_byte;
    reg        rd_txn;
    reg  [6:0] addr;
    reg        tx_load;
    reg  [7:0] tx_sh;
    reg        miso_q;
    reg  [2:0] byte_idx;
    reg        wr_stb;
    reg  [6:0] wr_addr;
    reg  [7:0] wr_data;
    reg  [7:0] rd_byte;

    wire [7:0] rx_byte  = {rx_sh[6:0], mosi_bit};
    wire       byte_end = cs_act & sclk_rise & (bit_cnt == 3'h7);
    wire       tx_fire  = cs_act & sclk_fall & tx_load;
    wire       at_bufrd = (addr == `ASB_ADDR_BUFRD);
    wire [2:0] set_bytes = sample_resolution_sel ? `ASB_BYTES_HI : `ASB_BYTES_LO; // [RL11]
    wire       last_byte = (byte_idx == set_bytes - 3'h1);

    // Storing stalls from the end of the address byte of a buffer read until chip select releases. [RL14]
    wire buf_reading = cs_act & rd_txn & ~first_byte & at_bufrd;

    assign spi_miso    = miso_q;
    assign spi_miso_oe = cs_act;

    // ================================================================
    // Sample storage
    reg [SW-1:0] mem [0:DEPTH-1];
    reg [6:0]    rd_ptr;
    reg [6:0]    wr_ptr;
    reg [6:0]    count;

    wire clear_now = wr_stb & (wr_addr == `ASB_ADDR_CLEAR);               // [RL13]
    wire [6:0] cap = sample_resolution_sel ? `ASB_CAP_HI : `ASB_CAP_LO;  // [RL2]
    wire pre_trig  = (mode == `ASB_BM_TRIG) & ~trigger_seen_flag;
    wire [6:0] lim = (pre_trig & (sample_threshold < cap)) ? sample_threshold : cap; // [RL3]
    wire full      = (count >= lim);
    wire drop_mode = (mode == `ASB_BM_STREAM) | newest_first_mode | pre_trig;
    wire drop_old  = drop_mode & full & (lim != 7'h00);                   // [RL8] [RL10]

    wire          stage_valid;
    wire [SW-1:0] stage_data;
    wire          drain_ready = ~buf_reading;                             // [RL14]
    wire          drain_fire  = stage_valid & drain_ready;
    // FIFO mode and post-trigger collection simply discard while full. [RL7] [RL9]
    wire do_store = drain_fire & buffer_active & (~full | drop_old) & ~clear_now; // [RL4] [RL18]
    wire do_pop   = tx_fire & at_bufrd & rd_txn & last_byte & (count != 7'h00);

    wire [6:0] rd_next = (rd_ptr == cap - 7'h01) ? 7'h00 : rd_ptr + 7'h01;
    wire [6:0] wr_next = (wr_ptr == cap - 7'h01) ? 7'h00 : wr_ptr + 7'h01;
    wire [6:0] wr_prev = (wr_ptr == 7'h00) ? cap - 7'h01 : wr_ptr - 7'h01;
    wire [6:0] head    = newest_first_mode ? wr_prev : rd_ptr;             // [RL10]

    asb_fifo #(
        .WIDTH (SW),
        .DEPTH (`ASB_STAGE_DEPTH),
        .AW    (`ASB_STAGE_AW)
    ) u_stage (
        .clk       (clk),
        .rst_n     (rst_n),
        .flush     (clear_now),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .in_data   ({sample_x, sample_y, sample_z}),
        .out_valid (stage_valid),
        .out_ready (drain_ready),
        .out_data  (stage_data)
    );

    // Byte count is count times six or three; both stay below 256.
    wire [8:0] lev3 = {2'b00, count} + {1'b0, count, 1'b0};
    wire [7:0] stored_byte_count = sample_resolution_sel ? {lev3[6:0], 1'b0} : lev3[7:0]; // [RL11]

    assign watermark = buffer_active & (mode != `ASB_BM_TRIG) &
                       (sample_threshold != 7'h00) & (count >= sample_threshold); // [RL1]

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ptr <= 7'h00;
            wr_ptr <= 7'h00;
            count  <= 7'h00;
        end else if (clear_now) begin
            rd_ptr <= 7'h00;
            wr_ptr <= 7'h00;
            count  <= 7'h00;                                              // [RL12]
        end else if (do_store) begin
            wr_ptr <= wr_next;
            if (drop_old) begin
                rd_ptr <= rd_next;
            end else begin
                count <= count + 7'h01;
            end
        end else if (do_pop) begin
            if (newest_first_mode) begin
                wr_ptr <= wr_prev;
            end else begin
                rd_ptr <= rd_next;
            end
            count <= count - 7'h01;
        end
    end

    always @(posedge clk) begin
        if (do_store) begin
            mem[wr_ptr] <= stage_data;
        end
    end

    // ================================================================
    // Register file
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_threshold      <= `ASB_THRESH_RST;
            buffer_active         <= MODE_RST[`ASB_ACTIVE_BIT];
            sample_resolution_sel <= MODE_RST[`ASB_RES_BIT];
            buffer_mode_hi        <= MODE_RST[`ASB_MODE_HI_BIT];
            buffer_mode_lo        <= MODE_RST[`ASB_MODE_LO_BIT];
        end else if (wr_stb) begin
            if (wr_addr == `ASB_ADDR_THRESH) begin
                sample_threshold <= wr_data[`ASB_THRESH_MSB:0];            // [RL1]
            end
            if (wr_addr == `ASB_ADDR_MODE) begin
                buffer_active         <= wr_data[`ASB_ACTIVE_BIT];         // [RL4]
                sample_resolution_sel <= wr_data[`ASB_RES_BIT];            // [RL5]
                buffer_mode_hi        <= wr_data[`ASB_MODE_HI_BIT];        // [RL6]
                buffer_mode_lo        <= wr_data[`ASB_MODE_LO_BIT];        // [RL6]
            end
        end
    end

    // A trigger in the same cycle as a clear write still registers.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trigger_seen_flag <= 1'b0;
        end else if (buffer_active & (mode == `ASB_BM_TRIG) & trigger_event) begin
            trigger_seen_flag <= 1'b1;                                    // [RL16]
        end else if (clear_now) begin
            trigger_seen_flag <= 1'b0;                                    // [RL13]
        end
    end

    // ================================================================
    // Read data mux
    wire [SW-1:0]  head_word = mem[head];
    wire [AXW-1:0] ax_x = head_word[SW-1:2*AXW];
    wire [AXW-1:0] ax_y = head_word[2*AXW-1:AXW];
    wire [AXW-1:0] ax_z = head_word[AXW-1:0];

    // Axis values pass through untouched, so the sign stays two's complement.
    always @* begin
        rd_byte = 8'h00;
        case (addr)
            `ASB_ADDR_THRESH: rd_byte = {1'b0, sample_threshold};
            `ASB_ADDR_MODE:   rd_byte = {buffer_active, sample_resolution_sel,
                                         4'h0, buffer_mode_hi, buffer_mode_lo};
            `ASB_ADDR_LEVEL:  rd_byte = stored_byte_count;
            `ASB_ADDR_STAT2:  rd_byte = {trigger_seen_flag, 7'h00};       // [RL16]
            `ASB_ADDR_BUFRD: begin
                if (count == 7'h00) begin
                    rd_byte = 8'h00;
                end else if (sample_resolution_sel) begin
                    case (byte_idx)
                        3'h0:    rd_byte = {ax_x[3:0], 4'h0};             // [RL15]
                        3'h1:    rd_byte = ax_x[AXW-1:4];
                        3'h2:    rd_byte = {ax_y[3:0], 4'h0};
                        3'h3:    rd_byte = ax_y[AXW-1:4];
                        3'h4:    rd_byte = {ax_z[3:0], 4'h0};
                        default: rd_byte = ax_z[AXW-1:4];
                    endcase
                end else begin
                    case (byte_idx)
                        3'h0:    rd_byte = ax_x[AXW-1:4];                 // [RL15]
                        3'h1:    rd_byte = ax_y[AXW-1:4];
                        default: rd_byte = ax_z[AXW-1:4];
                    endcase
                end
            end
            default:          rd_byte = 8'h00;
        endcase
    end

    // ================================================================
    // SPI slave, mode 0: sample on rising edge, shift out on falling edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt    <= 3'h0;
            rx_sh      <= 8'h00;
            first_byte <= 1'b1;
            rd_txn     <= 1'b0;
            addr       <= 7'h00;
            tx_load    <= 1'b0;
            tx_sh      <= 8'h00;
            miso_q     <= 1'b0;
            byte_idx   <= 3'h0;
            wr_stb     <= 1'b0;
            wr_addr    <= 7'h00;
            wr_data    <= 8'h00;
        end else begin
            wr_stb <= 1'b0;
            if (!cs_act) begin
                // A new transaction always starts a fresh sample set.
                bit_cnt    <= 3'h0;
                first_byte <= 1'b1;
                rd_txn     <= 1'b0;
                tx_load    <= 1'b0;
                byte_idx   <= 3'h0;
            end else begin
                if (sclk_rise) begin
                    rx_sh   <= rx_byte;
                    bit_cnt <= bit_cnt + 3'h1;
                end
                if (byte_end) begin
                    if (first_byte) begin
                        first_byte <= 1'b0;
                        addr       <= rx_byte[6:0];
                        rd_txn     <= rx_byte[`ASB_RD_FLAG_BIT];           // [RL17]
                        tx_load    <= rx_byte[`ASB_RD_FLAG_BIT];
                    end else if (rd_txn) begin
                        tx_load <= 1'b1;
                    end else begin
                        wr_stb  <= 1'b1;
                        wr_addr <= addr;
                        wr_data <= rx_byte;
                        addr    <= addr + 7'h01;
                    end
                end
                if (sclk_fall) begin
                    if (tx_load) begin
                        tx_load <= 1'b0;
                        miso_q  <= rd_byte[7];
                        tx_sh   <= {rd_byte[6:0], 1'b0};
                        if (at_bufrd) begin
                            // The read address stays put and walks the set. [RL14]
                            byte_idx <= last_byte ? 3'h0 : byte_idx + 3'h1;
                        end else begin
                            addr <= addr + 7'h01;
                        end
                    end else begin
                        miso_q <= tx_sh[7];
                        tx_sh  <= {tx_sh[6:0], 1'b0};
                    end
                end
            end
        end
    end

endmodule

// ### test/asb_buffer_ctrl_chk.sv
// Port-level assertions for the sample buffer controller.
`timescale 1ns/10ps
module asb_buffer_ctrl_chk (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Watched ports
    input wire spi_sclk,
    input wire spi_cs_n,
    input wire spi_miso,
    input wire spi_miso_oe,
    input wire sample_valid,
    input wire sample_ready,
    input wire watermark
);
    // ========
    // Helper logic
    // Counting cs high cycles lets the checks allow for the chip-select synchroniser.
    reg [4:0] cs_hi_cnt;
    reg [3:0] acc_hist;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_hi_cnt <= 5'h00;
            acc_hist  <= 4'h0;
        end else begin
            if (!spi_cs_n) cs_hi_cnt <= 5'h00;
            else if (cs_hi_cnt != 5'h1F) cs_hi_cnt <= cs_hi_cnt + 5'h01;
            acc_hist <= {acc_hist[2:0], sample_valid & sample_ready};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ========
    // Assertions
    AST_OE_OFF: assert property (spi_cs_n [*6] |-> !spi_miso_oe)
        else $error("miso enable high with chip select idle");
    AST_OE_ON: assert property ((!spi_cs_n) [*6] |-> spi_miso_oe)
        else $error("miso enable low with chip select active");
    AST_MISO_HOLD: assert property ((spi_sclk && !spi_cs_n) [*6] |-> $stable(spi_miso))
        else $error("miso moved while serial clock high");
    AST_RDY_DRAIN: assert property (cs_hi_cnt >= 5'h10 |-> sample_ready)
        else $error("sample input stalled with no buffer read open");
    AST_RDY_FALL: assert property ($fell(sample_ready) |-> cs_hi_cnt < 5'h08)
        else $error("sample input stalled outside a transaction");
    AST_RST_OUT: assert property ($rose(rst_n) |-> sample_ready && !watermark)
        else $error("outputs wrong after reset release");
    AST_WM_RISE: assert property ($rose(watermark) && cs_hi_cnt >= 5'h10 |-> acc_hist != 4'h0)
        else $error("watermark rose without a new sample");
    AST_WM_FALL: assert property ($fell(watermark) |-> cs_hi_cnt < 5'h10)
        else $error("watermark fell without host access");

    cover property ($rose(watermark));
    cover property ($fell(sample_ready));
    cover property (!spi_cs_n && spi_miso);
endmodule

bind asb_buffer_ctrl asb_buffer_ctrl_chk i_asb_buffer_ctrl_chk (
    .clk          (clk),
    .rst_n        (rst_n),
    .spi_sclk     (spi_sclk),
    .spi_cs_n     (spi_cs_n),
    .spi_miso     (spi_miso),
    .spi_miso_oe  (spi_miso_oe),
    .sample_valid (sample_valid),
    .sample_ready (sample_ready),
    .watermark    (watermark)
);

// ### test/asb_spi_host.sv
// SPI host model running mode 0 register and buffer transactions.
`timescale 1ns/10ps
module asb_spi_host #(
    parameter HALF = 8
) (
    // Clock
    input  wire clk,
    // SPI pins
    output reg  spi_sclk,
    output reg  spi_cs_n,
    output reg  spi_mosi,
    input  wire spi_miso,
    input  wire spi_miso_oe
);
    reg [7:0] rxb [0:5];

    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    task wait_clk(input integer n);
        repeat (n) @(negedge clk);
    endtask

    // Half periods well above the synchroniser delay keep miso settled at the sample.
    task xbyte(input [7:0] tx, output [7:0] rx);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                spi_mosi = tx[i];
                wait_clk(HALF);
                spi_sclk = 1'b1;
                rx[i] = spi_miso_oe ? spi_miso : ~tx[i];
                wait_clk(HALF);
                spi_sclk = 1'b0;
            end
        end
    endtask

    // Reads carry the top address bit; buffer reads come in whole sets.
    task txn(input [7:0] a, input [7:0] d, input integer n);
        integer k;
        reg [7:0] junk;
        begin
            spi_cs_n = 1'b0;
            wait_clk(HALF);
            xbyte(a, junk);
            for (k = 0; k < n; k = k + 1)
                xbyte(d, rxb[k]);
            wait_clk(HALF);
            spi_cs_n = 1'b1;
            spi_mosi = ~spi_mosi;
            wait_clk(2 * HALF);
        end
    endtask
endmodule

// ### test/tb_asb_buffer_ctrl.sv
// Self-checking testbench of the sample buffer controller.
`timescale 1ns/10ps
`include "asb_defines.vh"
module tb_asb_buffer_ctrl;
    reg        clk, rst_n, sample_valid, trigger_event;
    reg [11:0] sample_x, sample_y, sample_z;
    reg [7:0]  nidx, b;
    wire       spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
    wire       sample_ready, watermark;
    integer    fails, check_count, cycles;

    asb_buffer_ctrl i_asb_buffer_ctrl (
        .clk(clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .sample_valid(sample_valid), .sample_ready(sample_ready),
        .sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z),
        .trigger_event(trigger_event), .watermark(watermark));
    asb_spi_host i_asb_spi_host (
        .clk(clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));

    // ========
    // Shared tasks
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", check_count, fails);
            if (fails == 0 && check_count > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    task check(input string nm, input [7:0] seen, input [7:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    task wr(input [6:0] a, input [7:0] d);
        i_asb_spi_host.txn({1'b0, a}, d, 1);
    endtask

    task chk_reg(input [6:0] a, input [7:0] exp, input string nm);
        begin
            i_asb_spi_host.txn({1'b1, a}, 8'h00, 1);
            check(nm, i_asb_spi_host.rxb[0], exp);
        end
    endtask

    task push(input integer n);
        integer k;
        begin
            for (k = 0; k < n; k = k + 1) begin
                @(negedge clk);
                sample_valid = 1'b1;
                sample_x = {nidx, 4'h5};
                sample_y = {~nidx, 4'hA};
                sample_z = {4'h9, nidx};
                while (!sample_ready) @(negedge clk);
                nidx = nidx + 8'h01;
            end
            @(negedge clk);
            sample_valid = 1'b0;
            repeat (6) @(negedge clk);
        end
    endtask

    function [7:0] ebyte(input [7:0] k, input integer i, input hi);
        integer a;
        reg [11:0] v;
        begin
            a = hi ? i / 2 : i;
            v = (a == 0) ? {k, 4'h5} : (a == 1) ? {~k, 4'hA} : {4'h9, k};
            ebyte = (hi && i % 2 == 0) ? {v[3:0], 4'h0} : v[11:4];
        end
    endfunction

    task rd_set(input [7:0] k, input hi);
        integer i;
        begin
            i_asb_spi_host.txn({1'b1, `ASB_ADDR_BUFRD}, 8'h00, hi ? 6 : 3);
            for (i = 0; i < (hi ? 6 : 3); i = i + 1)
                check("buffer byte", i_asb_spi_host.rxb[i], ebyte(k, i, hi));
        end
    endtask

    // ========
    // Scenarios
    task t_regs;
        begin
            chk_reg(`ASB_ADDR_THRESH, 8'h00, "threshold");
            chk_reg(`ASB_ADDR_MODE, 8'h00, "mode");
            chk_reg(`ASB_ADDR_LEVEL, 8'h00, "level");
            wr(`ASB_ADDR_MODE, 8'h7F);
            chk_reg(`ASB_ADDR_MODE, 8'h43, "mode");
            wr(`ASB_ADDR_THRESH, 8'hFF);
            chk_reg(`ASB_ADDR_THRESH, 8'h7F, "threshold");
            chk_reg(7'h40, 8'h00, "unmapped");
            push(2);
            chk_reg(`ASB_ADDR_LEVEL, 8'h00, "level");
        end
    endtask

    task t_fifo;
        begin
            wr(`ASB_ADDR_THRESH, 8'h03);
            wr(`ASB_ADDR_MODE, 8'hC0);
            b = nidx;
            push(2);
            chk_reg(`ASB_ADDR_LEVEL, 8'h0C, "level");
            check("watermark", {7'h00, watermark}, 8'h00);
            push(1);
            check("watermark", {7'h00, watermark}, 8'h01);
            fork
                rd_set(b, 1'b1);
                begin
                    // Start pushing once the buffer read is open so staging stalls.
                    repeat (200) @(negedge clk);
                    push(10);
                end
            join
            chk_reg(`ASB_ADDR_LEVEL, 8'h48, "level");
            push(35);
            chk_reg(`ASB_ADDR_LEVEL, 8'hF6, "level");
            wr(`ASB_ADDR_CLEAR, 8'h5A);
            chk_reg(`ASB_ADDR_LEVEL, 8'h00, "level");
            check("watermark", {7'h00, watermark}, 8'h00);
        end
    endtask

    task t_stream_lifo;
        begin
            wr(`ASB_ADDR_MODE, 8'h81);
            b = nidx;
            push(86);
            chk_reg(`ASB_ADDR_LEVEL, 8'hFC, "level");
            rd_set(b + 8'h02, 1'b0);
            wr(`ASB_ADDR_MODE, 8'h83);
            wr(`ASB_ADDR_CLEAR, 8'h00);
            b = nidx;
            push(3);
            rd_set(b + 8'h02, 1'b0);
            rd_set(b + 8'h01, 1'b0);
            chk_reg(`ASB_ADDR_LEVEL, 8'h03, "level");
        end
    endtask

    task t_trig;
        begin
            wr(`ASB_ADDR_THRESH, 8'h02);
            wr(`ASB_ADDR_MODE, 8'hC2);
            wr(`ASB_ADDR_CLEAR, 8'hFF);
            push(5);
            chk_reg(`ASB_ADDR_LEVEL, 8'h0C, "level");
            check("watermark", {7'h00, watermark}, 8'h00);
            chk_reg(`ASB_ADDR_STAT2, 8'h00, "trigger");
            @(negedge clk);
            trigger_event = 1'b1;
            @(negedge clk);
            trigger_event = 1'b0;
            chk_reg(`ASB_ADDR_STAT2, 8'h80, "trigger");
            b = nidx;
            push(1);
            chk_reg(`ASB_ADDR_LEVEL, 8'h12, "level");
            rd_set(b - 8'h02, 1'b1);
            wr(`ASB_ADDR_CLEAR, 8'h01);
            chk_reg(`ASB_ADDR_STAT2, 8'h00, "trigger");
        end
    endtask

    // ========
    // Clock, timeout and main sequence
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 60000) begin
            fails = fails + 1;
            complete_run;
        end
    end

    initial begin
        fails = 0;
        check_count = 0;
        cycles = 0;
        nidx = 8'h00;
        b = 8'h00;
        rst_n = 1'b0;
        sample_valid = 1'b0;
        trigger_event = 1'b0;
        sample_x = 12'h000;
        sample_y = 12'h000;
        sample_z = 12'h000;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        t_regs;
        t_fifo;
        t_stream_lifo;
        t_trig;
        complete_run;
    end
endmodule
